// >>> scms_clock_select.v
// clock mode selection, baud rate divider, dpll reference and time-slot windows for one channel
// assumes all pin inputs synchronous to CLOCK_I; pin clocks arrive as sampled levels and become enables
`timescale 1ns/1ps
`default_nettype none
`include "scms_regs.vh"
module scms_clock_select (
  // clock and reset
  input  wire                      CLOCK_I,
  input  wire                      SRST_I,
  // configuration
  input  wire [2:0]                CLOCK_MODE_FIELD_I,
  input  wire                      TX_CLOCK_PIN_OUTPUT_ENABLE_I,
  input  wire                      TX_CLOCK_SOURCE_SELECT_I,
  input  wire [`SCMS_DIV_W-1:0]    DIVIDER_SETTING_I,
  input  wire [`SCMS_WIDTH_W-1:0]  RX_SLOT_WIDTH_I,
  input  wire [`SCMS_WIDTH_W-1:0]  TX_SLOT_WIDTH_I,
  input  wire [`SCMS_POS_W-1:0]    RX_SLOT_POSITION_I,
  input  wire [`SCMS_POS_W-1:0]    TX_SLOT_POSITION_I,
  // pins, sampled levels
  input  wire                      RX_CLOCK_PIN_I,
  input  wire                      TX_CLOCK_PIN_I,
  input  wire                      AUX_CLOCK_PIN_I,
  input  wire                      OSC_CLOCK_I,
  input  wire                      CLEAR_TO_SEND_N_I,
  // transmitter status
  input  wire                      CLOSING_FLAG_SECOND_LAST_I,
  input  wire                      TX_REQUEST_I,
  // outputs
  output reg                       TX_CLOCK_PIN_O,
  output reg                       TX_CLOCK_PIN_OE_O,
  output reg                       RX_CLOCK_EN_O,
  output reg                       TX_CLOCK_EN_O,
  output reg                       SYS_CLOCK_EN_O,
  output reg                       DPLL_REF_EN_O,
  output reg                       RX_WINDOW_O,
  output reg                       TX_WINDOW_O,
  output reg                       TX_ENABLE_O,
  output reg                       REQUEST_TO_SEND_N_O
);
  ////////////////////////////////////////////////////////////////////////////
  // edge detection of sampled pin clocks
  // pins are levels here; a rising edge becomes a one-cycle enable
  reg        rx_pin_d;
  reg        tx_pin_d;
  reg        aux_pin_d;
  reg        osc_d;
  wire       rx_rise   = RX_CLOCK_PIN_I & ~rx_pin_d;
  wire       tx_rise   = TX_CLOCK_PIN_I & ~tx_pin_d;
  wire       aux_rise  = AUX_CLOCK_PIN_I & ~aux_pin_d;
  wire       osc_rise  = OSC_CLOCK_I & ~osc_d;
  wire [2:0] mode      = CLOCK_MODE_FIELD_I;
  wire       slot_mode = (mode == `SCMS_MODE_SLOT);
  wire       next_rx_win;
  wire       next_tx_win;

  always @(posedge CLOCK_I) begin
    if (SRST_I) begin
      // load the pin levels so that release brings no false edge
      rx_pin_d  <= RX_CLOCK_PIN_I;
      tx_pin_d  <= TX_CLOCK_PIN_I;
      aux_pin_d <= AUX_CLOCK_PIN_I;
      osc_d     <= OSC_CLOCK_I;
    end else begin
      rx_pin_d  <= RX_CLOCK_PIN_I;
      tx_pin_d  <= TX_CLOCK_PIN_I;
      aux_pin_d <= AUX_CLOCK_PIN_I;
      osc_d     <= OSC_CLOCK_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // baud rate divider: setting 0 divides by 1, n divides by 2n
  // counts source edges only; ticks leave as one-cycle pulses
  // setting 0 bypasses the count so every source edge ticks
  wire                  brg_src = (mode == `SCMS_MODE_OSC_RX || mode == `SCMS_MODE_OSC_RXTX) ? osc_rise : rx_rise;
  reg [`SCMS_DIV_W:0]   brg_cnt;
  reg                   brg_tick;
  wire [`SCMS_DIV_W:0]  brg_top = {DIVIDER_SETTING_I, 1'b0} - {{`SCMS_DIV_W{1'b0}}, 1'b1};

  always @(posedge CLOCK_I) begin
    if (SRST_I) begin
      brg_cnt  <= {(`SCMS_DIV_W+1){1'b0}};
      brg_tick <= 1'b0;
    end else begin
      brg_tick <= 1'b0;
      if (brg_src) begin
        if (DIVIDER_SETTING_I == {`SCMS_DIV_W{1'b0}} || brg_cnt >= brg_top) begin
          brg_cnt  <= {(`SCMS_DIV_W+1){1'b0}};
          brg_tick <= 1'b1;
        end else begin
          brg_cnt <= brg_cnt + {{`SCMS_DIV_W{1'b0}}, 1'b1};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // divide by 16: stands in for the dpll bit clock and the brg/16 clock
  // dpll phase tracking is not modelled; the tick keeps the bit rate only
  reg [3:0] div16;
  reg       div16_tick;
  reg       div16_level;
  always @(posedge CLOCK_I) begin
    if (SRST_I) begin
      div16       <= 4'h0;
      div16_tick  <= 1'b0;
      div16_level <= 1'b0;
    end else begin
      div16_tick <= 1'b0;
      if (brg_tick) begin
        div16 <= div16 + 4'h1;
        if (div16 == `SCMS_DPLL_CNT_MAX)
          div16_tick <= 1'b1;
        div16_level <= div16[3];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock source selection
  reg rx_en;
  reg tx_en;
  always @* begin
    rx_en = 1'b0;
    tx_en = 1'b0;
    case (mode)
      `SCMS_MODE_EXT: begin
        rx_en = rx_rise;
        tx_en = tx_rise;
      end
      `SCMS_MODE_STROBE: begin
        // strobe levels qualify the shared rx pin clock
        rx_en = rx_rise & AUX_CLOCK_PIN_I;
        tx_en = rx_rise & TX_CLOCK_PIN_I;
      end
      `SCMS_MODE_DPLL_RX, `SCMS_MODE_OSC_RX: begin
        rx_en = div16_tick;
        tx_en = TX_CLOCK_SOURCE_SELECT_I ? div16_tick : tx_rise;
      end
      `SCMS_MODE_DPLL_RXTX, `SCMS_MODE_OSC_RXTX: begin
        rx_en = div16_tick;
        tx_en = div16_tick;
      end
      `SCMS_MODE_OSC: begin
        rx_en = osc_rise;
        tx_en = osc_rise;
      end
      `SCMS_MODE_SLOT: begin
        // shared rx pin clock, only inside each direction's window
        rx_en = rx_rise & next_rx_win;
        tx_en = rx_rise & next_tx_win;
      end
      default: begin
        rx_en = 1'b0;
        tx_en = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // time-slot window generators, one per direction
  reg  [`SCMS_POS_W:0]    frame_cnt;
  wire [1:0]              win_now;
  // frame counter saturates so a missing sync leaves every window shut
  wire [1:0]              win_last;
  always @(posedge CLOCK_I) begin
    if (SRST_I) begin
      frame_cnt <= {(`SCMS_POS_W+1){1'b1}};
    end else if (slot_mode && rx_rise) begin
      if (aux_rise)
        frame_cnt <= {(`SCMS_POS_W+1){1'b0}};
      else if (frame_cnt != {(`SCMS_POS_W+1){1'b1}})
        frame_cnt <= frame_cnt + {{`SCMS_POS_W{1'b0}}, 1'b1};
    end
  end

  // index 0 is the receive window, index 1 the transmit window
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : slot
      wire [`SCMS_POS_W-1:0]   pos = (g == 0) ? RX_SLOT_POSITION_I : TX_SLOT_POSITION_I;
      wire [`SCMS_WIDTH_W-1:0] wid = (g == 0) ? RX_SLOT_WIDTH_I : TX_SLOT_WIDTH_I;
      reg  [`SCMS_WIDTH_W:0]   left;
      wire                     start = (frame_cnt == {1'b0, pos});
      always @(posedge CLOCK_I) begin
        if (SRST_I) begin
          left <= {(`SCMS_WIDTH_W+1){1'b0}};
        end else if (!slot_mode) begin
          left <= {(`SCMS_WIDTH_W+1){1'b0}};
        end else if (rx_rise) begin
          if (start)
            left <= {1'b0, wid} + {{`SCMS_WIDTH_W{1'b0}}, 1'b1}; // width field n means n+1 bits
          else if (left != {(`SCMS_WIDTH_W+1){1'b0}})
            left <= left - {{`SCMS_WIDTH_W{1'b0}}, 1'b1};
        end
      end
      assign win_now[g]  = (left != {(`SCMS_WIDTH_W+1){1'b0}});
      assign win_last[g] = (left == {{`SCMS_WIDTH_W{1'b0}}, 1'b1});
    end
  endgenerate
  assign next_rx_win = win_now[0];
  assign next_tx_win = win_now[1];

  ////////////////////////////////////////////////////////////////////////////
  // tx clock pin function: which modes may drive it and with what
  reg next_tx_pin_oe;
  reg next_tx_pin;
  always @* begin
    next_tx_pin_oe = 1'b0;
    next_tx_pin    = 1'b1;
    case (mode)
      `SCMS_MODE_DPLL_RX, `SCMS_MODE_OSC_RX: begin
        // only the divider/16 clock may leave; a pin-fed tx clock never does
        next_tx_pin_oe = TX_CLOCK_SOURCE_SELECT_I;
        next_tx_pin    = div16_level;
      end
      `SCMS_MODE_DPLL_RXTX, `SCMS_MODE_OSC_RXTX: begin
        next_tx_pin_oe = 1'b1;
        next_tx_pin    = div16_level;
      end
      `SCMS_MODE_OSC: begin
        next_tx_pin_oe = 1'b1;
        next_tx_pin    = OSC_CLOCK_I;
      end
      `SCMS_MODE_SLOT: begin
        // low marks the transmit window; high idles between windows
        next_tx_pin_oe = 1'b1;
        next_tx_pin    = ~next_tx_win;
      end
      default: begin
        // modes 0 and 1 read the pin, so it is never driven there
        next_tx_pin_oe = 1'b0;
        next_tx_pin    = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // request-to-send, clear-to-send and registered outputs
  // cts is a plain level: no window qualifies it, so it also stops between windows
  wire cts_ok  = ~CLEAR_TO_SEND_N_I;
  // hold keeps rts inactive until the transmitter drops its request
  reg  rts_hold;
  always @(posedge CLOCK_I) begin
    if (SRST_I) begin
      rts_hold <= 1'b0;
    end else if (!slot_mode || !TX_REQUEST_I) begin
      rts_hold <= 1'b0;
    end else if (tx_en && win_last[1] && CLOSING_FLAG_SECOND_LAST_I) begin
      rts_hold <= 1'b1;
    end
  end

  always @(posedge CLOCK_I) begin
    if (SRST_I) begin
      TX_CLOCK_PIN_O      <= 1'b1;
      TX_CLOCK_PIN_OE_O   <= 1'b0;
      RX_CLOCK_EN_O       <= 1'b0;
      TX_CLOCK_EN_O       <= 1'b0;
      SYS_CLOCK_EN_O      <= 1'b0;
      DPLL_REF_EN_O       <= 1'b0;
      RX_WINDOW_O         <= 1'b0;
      TX_WINDOW_O         <= 1'b0;
      TX_ENABLE_O         <= 1'b0;
      REQUEST_TO_SEND_N_O <= 1'b1;
    end else begin
      RX_CLOCK_EN_O  <= rx_en;
      TX_CLOCK_EN_O  <= tx_en & (~slot_mode | cts_ok);
      SYS_CLOCK_EN_O <= tx_en;
      DPLL_REF_EN_O  <= brg_tick;
      RX_WINDOW_O    <= next_rx_win;
      TX_WINDOW_O    <= next_tx_win;
      TX_ENABLE_O    <= TX_REQUEST_I & cts_ok;
      REQUEST_TO_SEND_N_O <= ~(TX_REQUEST_I & ~rts_hold);
      TX_CLOCK_PIN_OE_O <= TX_CLOCK_PIN_OUTPUT_ENABLE_I & next_tx_pin_oe;
      TX_CLOCK_PIN_O    <= next_tx_pin;
    end
  end
endmodule
`default_nettype wire

// >>> scms_regs.vh
// constants for the serial channel clock mode select block
// assumes inclusion by the block's single design file
`ifndef SCMS_REGS_VH
`define SCMS_REGS_VH
`define SCMS_MODE_EXT       3'h0
`define SCMS_MODE_STROBE    3'h1
`define SCMS_MODE_DPLL_RX   3'h2
`define SCMS_MODE_DPLL_RXTX 3'h3
`define SCMS_MODE_OSC       3'h4
`define SCMS_MODE_SLOT      3'h5
`define SCMS_MODE_OSC_RX    3'h6
`define SCMS_MODE_OSC_RXTX  3'h7
`define SCMS_DIV_W          10
`define SCMS_BRG_POST       4'hf
`define SCMS_WIDTH_W        8
`define SCMS_POS_W          9
`define SCMS_DPLL_CNT_MAX   4'hf
`endif

// >>> scms_clock_select_chk.sv
// checker: clock enables, tx pin marker, cts gating
// assumes binding onto the block with pins as sampled levels
`timescale 1ns/1ps
`default_nettype none
module scms_chk (
  input wire logic       CLOCK_I, SRST_I, TX_CLOCK_PIN_OUTPUT_ENABLE_I,
  input wire logic [2:0] CLOCK_MODE_FIELD_I,
  input wire logic [9:0] DIVIDER_SETTING_I,
  input wire logic       RX_CLOCK_PIN_I, TX_CLOCK_PIN_I, AUX_CLOCK_PIN_I, OSC_CLOCK_I,
  input wire logic       CLEAR_TO_SEND_N_I, TX_CLOCK_PIN_O, TX_CLOCK_PIN_OE_O,
  input wire logic       RX_CLOCK_EN_O, TX_CLOCK_EN_O, SYS_CLOCK_EN_O,
  input wire logic       DPLL_REF_EN_O, TX_WINDOW_O, TX_ENABLE_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);
  logic       q_rx, q_tx, q_osc, q_rst;
  logic [2:0] q_m;
  always @(posedge CLOCK_I) begin
    q_rx  <= RX_CLOCK_PIN_I;
    q_tx  <= TX_CLOCK_PIN_I;
    q_osc <= OSC_CLOCK_I;
    q_rst <= SRST_I;
    q_m   <= CLOCK_MODE_FIELD_I;
  end
  // mode held since last edge, then rising pin edges
  wire logic [2:0] m   = CLOCK_MODE_FIELD_I;
  wire logic       st  = !q_rst && m == q_m;
  wire logic       rxu = st && RX_CLOCK_PIN_I && !q_rx;
  wire logic       txu = st && TX_CLOCK_PIN_I && !q_tx;
  wire logic       osu = st && OSC_CLOCK_I && !q_osc;
  property p_oe; st && m != 3'h5 && !$past(TX_CLOCK_PIN_OUTPUT_ENABLE_I) |-> !TX_CLOCK_PIN_OE_O; endproperty
  a_oe: assert property (p_oe) else $error("tx pin driven while disabled");
  property p_ref; rxu && m == 3'h2 && DIVIDER_SETTING_I == 10'h000 |-> ##[1:2] DPLL_REF_EN_O; endproperty
  a_ref: assert property (p_ref) else $error("reference tick missing");
  property p_sys; TX_CLOCK_EN_O |-> SYS_CLOCK_EN_O; endproperty
  a_sys: assert property (p_sys) else $error("system enable not with tx");
  property p_m0rx; rxu && m == 3'h0 |=> RX_CLOCK_EN_O; endproperty
  a_m0rx: assert property (p_m0rx) else $error("rx enable missing");
  property p_m0tx; txu && m == 3'h0 |=> TX_CLOCK_EN_O; endproperty
  a_m0tx: assert property (p_m0tx) else $error("tx enable missing");
  property p_m1; rxu && m == 3'h1 |=> RX_CLOCK_EN_O == $past(AUX_CLOCK_PIN_I); endproperty
  a_m1: assert property (p_m1) else $error("rx strobe ignored");
  property p_m4; osu && m == 3'h4 |=> RX_CLOCK_EN_O && TX_CLOCK_EN_O; endproperty
  a_m4: assert property (p_m4) else $error("oscillator enables missing");
  property p_mark; st && m == 3'h5 && TX_WINDOW_O |-> !TX_CLOCK_PIN_O; endproperty
  a_mark: assert property (p_mark) else $error("slot marker high in window");
  property p_cts; st && m == 3'h5 && $past(CLEAR_TO_SEND_N_I) |-> !TX_CLOCK_EN_O && !TX_ENABLE_O; endproperty
  a_cts: assert property (p_cts) else $error("transmit while clear inactive");
endmodule
bind scms_clock_select scms_chk u_chk (.*);
`default_nettype wire

// >>> scms_line_model.sv
// far side: free-running line clocks, frame sync, crystal clock
// assumes rising system clock samples these levels
`timescale 1ns/1ps
`default_nettype none
module scms_line_model (
  input  wire logic clk,
  output wire logic rx_pin,
  output wire logic tx_pin,
  output wire logic aux_pin,
  output wire logic osc_pin
);
  int n = 0;
  always @(negedge clk) n <= n + 1;
  assign rx_pin  = (n % 8) < 4;
  assign tx_pin  = (n % 10) < 5;  // rx/tx ratio 1.25
  assign aux_pin = (n % 64) < 8;  // sync rises with rx, one rx period
  assign osc_pin = (n % 4) < 2;
endmodule
`default_nettype wire

// >>> scms_clock_select_tb.sv
// testbench: clock mode table, slot windows, cts gating
// assumes the line model free-runs all pin clocks
`timescale 1ns/1ps
`default_nettype none
module scms_clock_select_tb;
  logic CLOCK_I = 0, SRST_I = 1, TX_CLOCK_PIN_OUTPUT_ENABLE_I = 0, TX_CLOCK_SOURCE_SELECT_I = 0;
  logic CLEAR_TO_SEND_N_I = 0, CLOSING_FLAG_SECOND_LAST_I = 0, TX_REQUEST_I = 0;
  logic [2:0] CLOCK_MODE_FIELD_I = 0;
  logic [9:0] DIVIDER_SETTING_I = 0;
  logic [7:0] RX_SLOT_WIDTH_I = 0, TX_SLOT_WIDTH_I = 0;
  logic [8:0] RX_SLOT_POSITION_I = 0, TX_SLOT_POSITION_I = 0;
  wire logic RX_CLOCK_PIN_I, TX_CLOCK_PIN_I, AUX_CLOCK_PIN_I, OSC_CLOCK_I;
  wire logic TX_CLOCK_PIN_O, TX_CLOCK_PIN_OE_O, RX_CLOCK_EN_O, TX_CLOCK_EN_O, SYS_CLOCK_EN_O;
  wire logic DPLL_REF_EN_O, RX_WINDOW_O, TX_WINDOW_O, TX_ENABLE_O, REQUEST_TO_SEND_N_O;
  int err_total = 0, n_checks = 0;
  integer c_rx, c_tx, c_sys, c_ref, c_pin, c_win, c_rwin, c_bad;
  logic pin_q;
  // mode, tss, div, tio, ref, rx, tx, pin rises per 640 cycles; -1 skips
  localparam int T[8][8] = '{'{0,0,0,0,-1,80,64,-1}, '{1,0,0,0,-1,10,-1,-1},
    '{2,1,0,0,80,5,5,-1}, '{2,0,0,0,80,5,64,-1}, '{3,0,0,1,80,5,5,5},
    '{4,0,0,1,-1,160,160,160}, '{6,1,1,0,80,5,5,-1}, '{7,0,0,0,160,10,10,-1}};
  scms_clock_select DUT (.*);
  scms_line_model u_line (.clk(CLOCK_I), .rx_pin(RX_CLOCK_PIN_I), .tx_pin(TX_CLOCK_PIN_I),
    .aux_pin(AUX_CLOCK_PIN_I), .osc_pin(OSC_CLOCK_I));
  always #2.5 CLOCK_I = ~CLOCK_I;
  always @(posedge CLOCK_I) begin
    pin_q <= TX_CLOCK_PIN_O;
    c_rx <= c_rx + RX_CLOCK_EN_O;
    c_tx <= c_tx + TX_CLOCK_EN_O;
    c_sys <= c_sys + SYS_CLOCK_EN_O;
    c_ref <= c_ref + DPLL_REF_EN_O;
    c_pin <= c_pin + (TX_CLOCK_PIN_O & ~pin_q);
    c_win <= c_win + TX_WINDOW_O;
    c_rwin <= c_rwin + RX_WINDOW_O;
    c_bad <= c_bad + (TX_WINDOW_O & TX_CLOCK_PIN_O);
  end
  task chk(input integer got, input integer exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task chkb(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // settle, then count over a span that holds whole periods of every clock
  task measure;
    repeat (300) @(negedge CLOCK_I);
    {c_rx, c_tx, c_sys, c_ref, c_pin, c_win, c_rwin, c_bad} = '0;
    repeat (640) @(negedge CLOCK_I);
  endtask
  task t_modes;
    for (int i = 0; i < 8; i++) begin
      CLOCK_MODE_FIELD_I = 3'(T[i][0]);
      TX_CLOCK_SOURCE_SELECT_I = 1'(T[i][1]);
      DIVIDER_SETTING_I = 10'(T[i][2]);
      TX_CLOCK_PIN_OUTPUT_ENABLE_I = 1'(T[i][3]);
      measure;
      if (T[i][4] >= 0) chk(c_ref, T[i][4]);
      chk(c_rx, T[i][5]);
      if (T[i][6] >= 0) chk(c_tx, T[i][6]);
      if (T[i][6] >= 0) chk(c_sys, T[i][6]);
      if (T[i][7] >= 0) chk(c_pin, T[i][7]);
      chkb(TX_CLOCK_PIN_OE_O, 1'(T[i][3]));
    end
    TX_CLOCK_PIN_OUTPUT_ENABLE_I = 1'b0;
  endtask
  task t_slots;
    CLOCK_MODE_FIELD_I = 3'h5;
    TX_SLOT_WIDTH_I = 8'h03;
    RX_SLOT_WIDTH_I = 8'h05; // no extended transparent mode, so any width
    RX_SLOT_POSITION_I = 9'h002;
    TX_REQUEST_I = 1'b1;
    measure;
    chk(c_win, 320);
    chk(c_rwin, 480);
    chk(c_bad, 0);
    chkb(TX_ENABLE_O, 1'b1);
    chkb(REQUEST_TO_SEND_N_O, 1'b0);
  endtask
  task t_rts;
    CLOSING_FLAG_SECOND_LAST_I = 1'b1;
    measure;
    chkb(REQUEST_TO_SEND_N_O, 1'b1);
    CLOSING_FLAG_SECOND_LAST_I = 1'b0;
    measure;
    chkb(REQUEST_TO_SEND_N_O, 1'b1);
    TX_REQUEST_I = 1'b0;
    repeat (2) @(negedge CLOCK_I);
    TX_REQUEST_I = 1'b1;
    repeat (2) @(negedge CLOCK_I);
    chkb(REQUEST_TO_SEND_N_O, 1'b0);
  endtask
  task t_cts;
    CLEAR_TO_SEND_N_I = 1'b1;
    measure;
    chk(c_tx, 0);
    chkb(TX_ENABLE_O, 1'b0);
    CLEAR_TO_SEND_N_I = 1'b0;
    TX_REQUEST_I = 1'b0;
  endtask
  task tally_and_finish;
    if (err_total == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge CLOCK_I);
    SRST_I = 1'b0;
    t_modes;
    t_slots;
    t_rts;
    t_cts;
    tally_and_finish;
  end
  initial begin
    #100000;
    err_total++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
